// ===== hw/ihp_host_port.sv
// Host register port: direct map, indirect access engine and config bytes 0-2
// What this block does
// R1 - Indirect mode decodes three host address bits
// R2 - Direct mode maps switch memories at 80h-FFh
// R3 - Busy flags synchronized commands until completion
// R4 - Read command fetches access memory registers synchronously
// R5 - Data registers follow address for plain reads
// R6 - Write command stores data registers, self-clearing
// R7 - Terminate ends pending command, clears busy
// R8 - Reset bit holds device and clears registers
// R9 - Internal address is high byte over low
// R10 - Internal map: config, ID, routing, access, conversion
// R11 - Unlisted addresses read zero, ignore writes
// R12 - Host writes zero to reserved config bits
// R13 - Diagnostic mode resets to one
// R14 - Test mode bypasses slave PLL, resets zero
// R15 - Analog PLL power-down and bypass reset one
// R16 - Bits 7:4 pick analog PLL reference
// R17 - Bits 9:8 pick slave timing source
// R18 - Bit 10 picks local clock pair
// R19 - Bit 11 advances slave PLL timing
// R20 - Auto mode switches sets on one-sided error
// R21 - Bit 13 selects set, bit 14 reports
// R22 - Bit 16 enables master drive of bus
// R23 - Diagnostic mode tri-states and loops bus signals
// R24 - Host polls busy before next synchronized step
// R25 - Eight-bit bus with chip select, strobes
`timescale 1ns/1ps
module ihp_host_port (
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  input  wire logic            host_cs_b,
  input  wire logic            host_wr_b,
  input  wire logic            host_rd_b,
  input  wire logic [9:0]      host_addr,
  input  wire logic [7:0]      host_data_in,
  output logic      [7:0]      host_data_out,
  output logic                 host_data_oe_b,
  input  wire logic            bus_err_a,
  input  wire logic            bus_err_b,
  output logic                 dev_reset,
  output ihp_pkg::ihp_cfg_t    cfg_out
);
  import ihp_pkg::*;

  // ==========================================================
  // Pin synchronisers
  ihp_pins_t pin_s1_q;
  ihp_pins_t pin_q;
  logic      wr_prev_q;
  logic      wr_act;
  logic      rd_act;
  logic      wr_evt;

  // Every pin passes two flops; strobes and data share the same lag
  always_ff @(posedge core_clk) begin
    pin_s1_q <= {host_cs_b, host_wr_b, host_rd_b, host_addr, host_data_in,
                 bus_err_a, bus_err_b};
    pin_q    <= pin_s1_q;
  end

  assign wr_act = !pin_q.cs_b && !pin_q.wr_b;  // R25
  assign rd_act = !pin_q.cs_b && !pin_q.rd_b;  // R25
  assign wr_evt = wr_act && !wr_prev_q;

  // Only the leading edge of a write strobe counts, so long strobes write once
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_act;
    end
  end

  // ==========================================================
  // Storage
  logic [7:0]  cfg_q [CFG_BYTES];
  logic [23:0] mem_q [MEM_WORDS];
  logic [7:0]  addr_lo_q;
  logic [7:0]  addr_hi_q;
  logic [23:0] dr_q;
  logic        srst_q;
  logic        set_use_q;
  logic        load_pend_q;
  logic [7:0]  slot_q;
  ihp_state_t  st_q;
  logic        op_wr_q;

  // ==========================================================
  // Host direct map decode
  logic       direct_en;
  logic       lo_hit;
  logic       dsw_hit;
  logic [2:0] off;
  logic       lo_wr;
  logic       cmd_wr;
  assign direct_en = cfg_q[CFG_DIRECT_IX][0];
  assign off       = pin_q.addr[2:0];
  // R1 R2
  assign lo_hit    = !direct_en || (pin_q.addr[9:3] == 7'h00);
  assign dsw_hit   = direct_en && (pin_q.addr[9:8] == 2'h0) && pin_q.addr[7];
  assign lo_wr     = wr_evt && lo_hit;
  assign cmd_wr    = lo_wr && (off == OFF_CMD_STATUS);

  // ==========================================================
  // Internal address decode
  logic [15:0] iaddr;
  logic        is_cfg;
  logic        is_id;
  logic        is_mem;
  logic        sync_wr;
  logic        sync_rd;
  logic [8:0]  mem_ix;
  assign iaddr   = {addr_hi_q, addr_lo_q};  // R9
  assign is_cfg  = (iaddr[15:8] == 8'h00) && (iaddr[7:0] <= CFG_LAST);  // R10
  assign is_id   = (iaddr[15:2] == DEV_ID_BASE[15:2]);  // R10
  assign is_mem  = !iaddr[15] && (iaddr[14:12] != 3'h0) && (iaddr[11:6] == 6'h00)
                   && ((iaddr[14:12] != REG_STREAM) || (iaddr[5:3] == 3'h0));  // R10
  assign sync_rd = is_mem && (iaddr[14:12] >= REG_TX_ACCESS)
                   && (iaddr[14:12] <= REG_RX_ACCESS);
  assign sync_wr = sync_rd || (is_mem && (iaddr[14:12] <= REG_RX_ROUTE));  // R3
  assign mem_ix  = {3'(iaddr[14:12] - 3'h1), iaddr[5:0]};

  // Register read path; anything unlisted returns zero
  logic [23:0] rd_word;
  logic [7:0]  cfg_rd;
  always_comb begin
    cfg_rd = cfg_q[iaddr[4:0]];
    if (iaddr[4:0] == 5'h01) begin
      cfg_rd[SET_USE_BIT] = set_use_q;  // R21
    end
    if (is_cfg) begin
      rd_word = {16'h0000, cfg_rd};
    end else if (is_id) begin
      rd_word = {16'h0000, 8'(DEV_ID_WORD >> {iaddr[1:0], 3'h0})};
    end else if (is_mem) begin
      rd_word = mem_q[mem_ix];
    end else begin
      rd_word = 24'h000000;  // R11
    end
  end

  // ==========================================================
  // Command sequencing
  logic term_cmd;
  logic rd_cmd;
  logic wr_cmd;
  logic slot_tick;
  logic finish;
  logic start_sync;
  assign term_cmd   = cmd_wr && pin_q.data[CMD_TERM_BIT];
  assign rd_cmd     = cmd_wr && pin_q.data[CMD_READ_BIT];
  assign wr_cmd     = cmd_wr && pin_q.data[CMD_WRITE_BIT];
  assign slot_tick  = (slot_q == SLOT_LAST);
  // Terminate completes the pending access at once instead of waiting
  assign finish     = (st_q == ST_WAIT) && (slot_tick || term_cmd);  // R7
  assign start_sync = ((wr_cmd && sync_wr) || (rd_cmd && sync_rd)) && !srst_q;

  // Access slot divider stands in for the switch state machine's free slot
  always_ff @(posedge core_clk) begin
    if (!rst_b || srst_q || slot_tick) begin
      slot_q <= 8'h00;
    end else begin
      slot_q <= slot_q + 8'h01;
    end
  end

  // Busy engine; a new command in the same byte as terminate starts afresh
  always_ff @(posedge core_clk) begin
    if (!rst_b || srst_q) begin
      st_q    <= ST_IDLE;  // R8
      op_wr_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (start_sync) begin
            st_q    <= ST_WAIT;  // R3
            op_wr_q <= wr_cmd;
          end
        end
        ST_WAIT: begin
          if (finish && start_sync && term_cmd) begin
            op_wr_q <= wr_cmd;
          end else if (finish) begin
            st_q <= ST_IDLE;  // R3
          end
        end
      endcase
    end
  end

  // Soft reset bit is set and cleared by software; the reset pin also clears it and drives dev_reset high
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      srst_q    <= 1'b0;
      dev_reset <= 1'b1;
    end else begin
      if (cmd_wr) begin
        srst_q <= pin_q.data[CMD_RESET_BIT];  // R8
      end
      dev_reset <= srst_q;  // R8
    end
  end

  // ==========================================================
  // Address and data registers
  logic data_wr;
  assign data_wr = lo_wr && (off >= OFF_DATA_ZERO) && (off <= OFF_DATA_TWO);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      addr_lo_q   <= 8'h00;
      addr_hi_q   <= 8'h00;
      load_pend_q <= 1'b0;
    end else begin
      if (lo_wr && (off == OFF_ADDR_LOW)) begin
        addr_lo_q <= pin_q.data;
      end
      if (lo_wr && (off == OFF_ADDR_HIGH)) begin
        addr_hi_q <= pin_q.data;
      end
      // A plain read needs no command, so refresh one cycle after the address
      load_pend_q <= (lo_wr && ((off == OFF_ADDR_LOW) || (off == OFF_ADDR_HIGH)))
                     || (rd_cmd && !sync_rd);  // R5
    end
  end

  // Data registers take host bytes, plain reads and finished synchronized reads
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dr_q <= 24'h000000;
    end else if (data_wr) begin
      unique case (off)
        OFF_DATA_ZERO: dr_q[7:0]   <= pin_q.data;
        OFF_DATA_ONE:  dr_q[15:8]  <= pin_q.data;
        default:       dr_q[23:16] <= pin_q.data;
      endcase
    end else if (finish && !op_wr_q) begin
      dr_q <= mem_q[mem_ix];  // R4
    end else if (load_pend_q && !sync_rd) begin
      dr_q <= rd_word;  // R5
    end
  end

  // ==========================================================
  // Switch memories: routing, parallel access and conversion
  logic        mem_we;
  logic [8:0]  mem_wix;
  logic [23:0] mem_wd;
  logic [8:0]  dsw_ix;
  assign dsw_ix = {3'(((pin_q.addr[7:6] == DSW_RX_SEL) ? REG_RX_ACCESS : REG_TX_ACCESS) - 3'h1),
                   pin_q.addr[5:0]};  // R2
  always_comb begin
    mem_we  = 1'b0;
    mem_wix = mem_ix;
    mem_wd  = dr_q;
    if (finish && op_wr_q) begin
      mem_we = 1'b1;  // R6
    end else if (wr_cmd && is_mem && !sync_wr && !srst_q) begin
      mem_we = 1'b1;  // R6
    end else if (wr_evt && dsw_hit) begin
      mem_we  = 1'b1;  // R2
      mem_wix = dsw_ix;
      mem_wd  = {mem_q[dsw_ix][23:8], pin_q.data};
    end
  end

  // Clearing the whole array in one cycle costs flops but keeps reset simple
  always_ff @(posedge core_clk) begin
    if (!rst_b || srst_q) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_q[i] <= 24'h000000;  // R8
      end
    end else if (mem_we) begin
      mem_q[mem_wix] <= mem_wd;
    end
  end

  // ==========================================================
  // Configuration bytes; reserved bits are masked to read zero
  logic cfg_we;
  assign cfg_we = wr_cmd && is_cfg && !srst_q;  // R6 R10

  always_ff @(posedge core_clk) begin
    if (!rst_b || srst_q) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg_q[i] <= 8'h00;
      end
      cfg_q[0] <= CFG0_RST;  // R13 R14 R15
    end else if (cfg_we) begin
      unique case (iaddr[4:0])
        5'h01:   cfg_q[1] <= dr_q[7:0] & CFG1_MASK;
        5'h02:   cfg_q[2] <= dr_q[7:0] & CFG2_MASK;
        default: cfg_q[iaddr[4:0]] <= dr_q[7:0];
      endcase
    end
  end

  // ==========================================================
  // Slave bus set selection
  logic cur_bad;
  logic oth_bad;
  assign cur_bad = set_use_q ? pin_q.err_b : pin_q.err_a;
  assign oth_bad = set_use_q ? pin_q.err_a : pin_q.err_b;

  // Auto mode never flips onto a set that is also failing
  always_ff @(posedge core_clk) begin
    if (!rst_b || srst_q) begin
      set_use_q <= 1'b0;
    end else if (!cfg_q[1][4]) begin
      set_use_q <= cfg_q[1][5];  // R21
    end else if (cur_bad && !oth_bad) begin
      set_use_q <= !set_use_q;  // R20
    end
  end

  // Configuration outputs to the timing logic
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_out <= '0;
    end else begin
      cfg_out.diag_mode   <= cfg_q[0][0];  // R13
      cfg_out.test_mode   <= cfg_q[0][1];  // R14
      cfg_out.analog_pll_pd     <= cfg_q[0][2];  // R15
      cfg_out.analog_pll_bypass <= cfg_q[0][3];  // R15
      cfg_out.analog_pll_ref    <= cfg_q[0][7:4];  // R16
      cfg_out.slave_mode  <= cfg_q[1][1:0];  // R17
      cfg_out.local_sel   <= cfg_q[1][2];  // R18
      cfg_out.slave_adv   <= cfg_q[1][3];  // R19
      cfg_out.slave_auto  <= cfg_q[1][4];  // R20
      cfg_out.slave_set   <= cfg_q[1][5];  // R21
      cfg_out.set_in_use  <= set_use_q;  // R21
      cfg_out.master_en   <= cfg_q[2][0] && !cfg_q[0][0];  // R22 R23
      cfg_out.ct_tristate <= cfg_q[0][0];  // R23
      cfg_out.ct_loopback <= cfg_q[0][0];  // R23
    end
  end

  // ==========================================================
  // Host read path
  logic [7:0] host_rd;

  always_comb begin
    host_rd = 8'h00;
    if (dsw_hit) begin
      host_rd = mem_q[dsw_ix][7:0];  // R2
    end else if (lo_hit) begin
      unique case (off)
        OFF_CMD_STATUS: host_rd = {srst_q, 6'h00, st_q == ST_WAIT};  // R3 R8
        OFF_ADDR_LOW:   host_rd = addr_lo_q;
        OFF_ADDR_HIGH:  host_rd = addr_hi_q;
        OFF_DATA_ZERO:  host_rd = dr_q[7:0];
        OFF_DATA_ONE:   host_rd = dr_q[15:8];
        OFF_DATA_TWO:   host_rd = dr_q[23:16];
        default:        host_rd = 8'h00;  // R1
      endcase
    end
  end

  // Drivers turn on only while chip select and read strobe are both low
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      host_data_out  <= 8'h00;
      host_data_oe_b <= 1'b1;
    end else begin
      host_data_out  <= host_rd;
      host_data_oe_b <= !rd_act;  // R25
    end
  end

  // ==========================================================
  // Checks
  chk_term_clears_busy: assert property (@(posedge core_clk) disable iff (!rst_b)  // R7
    (term_cmd && !start_sync) |=> (st_q == ST_IDLE)) else $error("busy after terminate");
  chk_busy_bounded: assert property (@(posedge core_clk) disable iff (!rst_b)  // R3
    $rose(st_q == ST_WAIT) |-> ##[1:123] (st_q == ST_IDLE)) else $error("busy too long");
  chk_sync_read_busy: assert property (@(posedge core_clk) disable iff (!rst_b)  // R4
    (rd_cmd && sync_rd && !srst_q && st_q == ST_IDLE) |=> (st_q == ST_WAIT))
    else $error("sync read did not set busy");
  chk_soft_reset_cfg: assert property (@(posedge core_clk) disable iff (!rst_b)  // R8 R13
    srst_q |=> (cfg_q[0] == CFG0_RST && cfg_q[1] == 8'h00 && st_q == ST_IDLE))
    else $error("soft reset did not clear");
  chk_addr_refresh: assert property (@(posedge core_clk) disable iff (!rst_b)  // R5 R9
    (lo_wr && off == OFF_ADDR_LOW && !sync_rd) ##1 (!data_wr && !finish && !sync_rd)
    |=> (dr_q == $past(rd_word))) else $error("data not refreshed");
  chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_b)  // R11
    (load_pend_q && !data_wr && !finish && !is_cfg && !is_id && !is_mem)
    |=> (dr_q == 24'h000000)) else $error("unmapped read nonzero");
  chk_reset_out: assert property (@(posedge core_clk) disable iff (!rst_b)  // R8
    (cmd_wr && pin_q.data[CMD_RESET_BIT]) |=> ##1 dev_reset) else $error("no device reset");
  chk_auto_switch: assert property (@(posedge core_clk) disable iff (!rst_b || srst_q) // R20
    (cfg_q[1][4] && !set_use_q && pin_q.err_a && !pin_q.err_b) |=> set_use_q)
    else $error("auto switch missed");
  chk_read_drive: assert property (@(posedge core_clk) disable iff (!rst_b)  // R25
    rd_act |=> (!host_data_oe_b && host_data_out == $past(host_rd)))
    else $error("read not driven");

endmodule : ihp_host_port

// ===== hw/ihp_pkg.sv
// Constants, types and register map of the indirect host register port
package ihp_pkg;

  // ==========================================================
  // Clock and internal access slot timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SLOT_TIME_NS  = 488;
  localparam int SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SLOT_LAST = 8'(SLOT_CYCLES - 1);

  // ==========================================================
  // Host direct map (3-bit low offsets)
  localparam logic [2:0] OFF_CMD_STATUS = 3'h0;
  localparam logic [2:0] OFF_ADDR_LOW   = 3'h1;
  localparam logic [2:0] OFF_ADDR_HIGH  = 3'h2;
  localparam logic [2:0] OFF_DATA_ZERO  = 3'h4;
  localparam logic [2:0] OFF_DATA_ONE   = 3'h5;
  localparam logic [2:0] OFF_DATA_TWO   = 3'h6;
  localparam logic [1:0] DSW_TX_SEL     = 2'h2;
  localparam logic [1:0] DSW_RX_SEL     = 2'h3;

  // Command/status bit positions
  localparam int CMD_BUSY_BIT  = 0;
  localparam int CMD_READ_BIT  = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam int CMD_TERM_BIT  = 3;
  localparam int CMD_RESET_BIT = 7;

  // ==========================================================
  // Internal address map
  localparam logic [7:0]  CFG_LAST      = 8'h14;
  localparam logic [15:0] DEV_ID_BASE   = 16'h00fc;
  localparam logic [2:0]  REG_STREAM    = 3'h1;
  localparam logic [2:0]  REG_RX_ROUTE  = 3'h3;
  localparam logic [2:0]  REG_TX_ACCESS = 3'h4;
  localparam logic [2:0]  REG_RX_ACCESS = 3'h5;
  localparam int          MEM_WORDS     = 448;
  localparam int          CFG_BYTES     = 21;
  localparam logic [4:0]  CFG_DIRECT_IX = 5'h0c;

  // Configuration reset values and writable masks
  localparam logic [7:0] CFG0_RST  = 8'h0d;
  localparam logic [7:0] CFG1_MASK = 8'h3f;
  localparam logic [7:0] CFG2_MASK = 8'h3b;
  localparam int         SET_USE_BIT = 6;

  // Arbitrary identification word, not tied to any part
  localparam logic [31:0] DEV_ID_WORD = 32'h0a5c_3e01;

  // ==========================================================
  typedef struct packed {
    logic       cs_b;
    logic       wr_b;
    logic       rd_b;
    logic [9:0] addr;
    logic [7:0] data;
    logic       err_a;
    logic       err_b;
  } ihp_pins_t;

  typedef struct packed {
    logic       diag_mode;
    logic       test_mode;
    logic       analog_pll_pd;
    logic       analog_pll_bypass;
    logic [3:0] analog_pll_ref;
    logic [1:0] slave_mode;
    logic       local_sel;
    logic       slave_adv;
    logic       slave_auto;
    logic       slave_set;
    logic       set_in_use;
    logic       master_en;
    logic       ct_tristate;
    logic       ct_loopback;
  } ihp_cfg_t;

  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} ihp_state_t;

endpackage : ihp_pkg

// ===== verification/ihp_host_model.sv
// Host processor model driving the 8-bit parallel register port
`timescale 1ns/1ps
module ihp_host_model
  import ihp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_oe_b,
  output ihp_pins_t       pins
);
  // ==========================================================
  // Strobe timing
  localparam int HOLD = 4;  // Three sync edges plus one for margin

  initial begin
    pins = '{cs_b: 1'b1, wr_b: 1'b1, rd_b: 1'b1, addr: 10'h3ff, data: 8'hff,
             err_a: 1'b0, err_b: 1'b0};
  end

  // Released lines show the inverse of their last value, never a stale copy
  task automatic idle_bus();
    pins.cs_b = 1'b1;
    pins.wr_b = 1'b1;
    pins.rd_b = 1'b1;
    pins.addr = ~pins.addr;
    pins.data = ~pins.data;
  endtask : idle_bus

  // Write: hold everything until the sync flops have seen it, then idle
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    pins.addr = a;
    pins.data = d;
    pins.cs_b = 1'b0;
    pins.wr_b = 1'b0;
    repeat (HOLD) @(posedge core_clk);
    #1;
    idle_bus();
    repeat (HOLD) @(posedge core_clk);  // Keeps strobes high long enough
  endtask : wr

  // Read: data is taken at the edge where it has stood for one cycle
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
    @(posedge core_clk);
    #1;
    pins.addr = a;
    pins.cs_b = 1'b0;
    pins.rd_b = 1'b0;
    repeat (HOLD) @(posedge core_clk);
    d  = rd_data;
    oe = rd_oe_b;
    #1;
    idle_bus();
    repeat (HOLD) @(posedge core_clk);
  endtask : rd

  // Bus set error levels seen by the slave timing selector
  task automatic set_err(input logic a, input logic b);
    @(posedge core_clk);
    #1;
    pins.err_a = a;
    pins.err_b = b;
  endtask : set_err

endmodule : ihp_host_model

// ===== verification/ihp_host_port_test.sv
// Self-checking bench for the indirect host register port
`timescale 1ns/1ps
module ihp_host_port_test;
  import ihp_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [9:0] A_CMD = {7'h0, OFF_CMD_STATUS};
  localparam logic [9:0] A_D0  = {7'h0, OFF_DATA_ZERO};
  logic       core_clk;
  logic       rst_b;
  logic [7:0] host_data_out;
  logic       host_data_oe_b;
  logic       dev_reset;
  ihp_cfg_t   cfg_out;
  ihp_pins_t  pins;
  int         error_cnt;
  int         checks;
  logic [7:0] rv;
  logic       oe;

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  ihp_host_port uut (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .host_cs_b      (pins.cs_b),
    .host_wr_b      (pins.wr_b),
    .host_rd_b      (pins.rd_b),
    .host_addr      (pins.addr),
    .host_data_in   (pins.data),
    .host_data_out  (host_data_out),
    .host_data_oe_b (host_data_oe_b),
    .bus_err_a      (pins.err_a),
    .bus_err_b      (pins.err_b),
    .dev_reset      (dev_reset),
    .cfg_out        (cfg_out)
  );

  ihp_host_model host (
    .core_clk (core_clk),
    .rd_data  (host_data_out),
    .rd_oe_b  (host_data_oe_b),
    .pins     (pins)
  );

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bit_chk(input logic seen, input logic exp);
    check({7'h0, seen}, {7'h0, exp});
  endtask : bit_chk

  // A wait that ran out is a mismatch and ends the run
  task automatic tmo();
    error_cnt++;
    $display("[ERR] %0t wait ran out, seen %h expected %h", $time, rv, 8'h00);
    test_done();
  endtask : tmo

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    host.rd(a, rv, oe);
    bit_chk(oe, 1'b0);
    check(rv, exp);
  endtask : rd_chk

  task automatic set_addr(input logic [15:0] a);
    host.wr({7'h0, OFF_ADDR_LOW}, a[7:0]);
    host.wr({7'h0, OFF_ADDR_HIGH}, a[15:8]);
  endtask : set_addr

  task automatic d3(input logic [23:0] w);
    host.wr(A_D0, w[7:0]);
    host.wr({7'h0, OFF_DATA_ONE}, w[15:8]);
    host.wr({7'h0, OFF_DATA_TWO}, w[23:16]);
  endtask : d3

  task automatic rd3(input logic [23:0] w);
    rd_chk(A_D0, w[7:0]);
    rd_chk({7'h0, OFF_DATA_ONE}, w[15:8]);
    rd_chk({7'h0, OFF_DATA_TWO}, w[23:16]);
  endtask : rd3

  // Config writes only use byte zero of the data registers
  task automatic cfg_wr(input logic [15:0] a, input logic [7:0] d);
    set_addr(a);
    host.wr(A_D0, d);
    host.wr(A_CMD, 8'h04);
  endtask : cfg_wr

  // Bounded busy poll; n counts reads that still showed busy
  task automatic poll(output int n);
    int i;
    n = 0;
    for (i = 0; i < 40; i++) begin
      host.rd(A_CMD, rv, oe);
      if (rv[0] !== 1'b1) break;
      n++;
    end
    if (i == 40) tmo();
    check(rv, 8'h00);
  endtask : poll

  // ==========================================================
  // Main sequence
  initial begin
    int i;
    int n;
    error_cnt = 0;
    checks = 0;
    rst_b = 1'b0;
    repeat (10) @(posedge core_clk);
    bit_chk(dev_reset, 1'b1);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    bit_chk(dev_reset, 1'b0);
    bit_chk(cfg_out.diag_mode, 1'b1);
    bit_chk(cfg_out.test_mode, 1'b0);
    bit_chk(cfg_out.analog_pll_pd, 1'b1);
    bit_chk(cfg_out.analog_pll_bypass, 1'b1);
    bit_chk(cfg_out.ct_tristate, 1'b1);
    rd_chk(A_CMD, 8'h00);
    set_addr(16'h0000);
    rd_chk(A_D0, CFG0_RST);
    rd_chk(10'h003, 8'h00);
    rd_chk(10'h007, 8'h00);
    // Master drive stays off while diagnostic mode holds the bus
    cfg_wr(16'h0002, 8'h01);
    bit_chk(cfg_out.master_en, 1'b0);
    for (int c = 0; c < 16; c++) begin
      if (c != 7) begin
        cfg_wr(16'h0000, {4'(c), 4'h4});
        check({4'h0, cfg_out.analog_pll_ref}, 8'(c));
      end
    end
    cfg_wr(16'h0000, 8'hf2);
    bit_chk(cfg_out.diag_mode, 1'b0);
    bit_chk(cfg_out.test_mode, 1'b1);
    bit_chk(cfg_out.analog_pll_pd, 1'b0);
    bit_chk(cfg_out.ct_loopback, 1'b0);
    bit_chk(cfg_out.master_en, 1'b1);
    rd_chk(A_CMD, 8'h00);
    set_addr(16'h0000);
    rd_chk(A_D0, 8'hf2);
    // Every slave source, with local pair and advance toggled alongside
    for (int c = 0; c < 4; c++) begin
      cfg_wr(16'h0001, {4'h0, c[0], c[1], c[1:0]});
      check({6'h0, cfg_out.slave_mode}, 8'(c));
      bit_chk(cfg_out.local_sel, c[1]);
      bit_chk(cfg_out.slave_adv, c[0]);
    end
    cfg_wr(16'h0001, 8'h20);
    bit_chk(cfg_out.set_in_use, 1'b1);
    set_addr(16'h0001);
    rd_chk(A_D0, 8'h60);
    // Auto mode: no swap while both sets fail, swap when only B fails
    host.set_err(1'b1, 1'b1);
    cfg_wr(16'h0001, 8'h30);
    repeat (20) @(posedge core_clk);
    bit_chk(cfg_out.set_in_use, 1'b1);
    bit_chk(cfg_out.slave_auto, 1'b1);
    bit_chk(cfg_out.slave_set, 1'b1);
    host.set_err(1'b0, 1'b1);
    for (i = 0; i < 20 && cfg_out.set_in_use !== 1'b0; i++) @(posedge core_clk);
    if (i == 20) tmo();
    host.set_err(1'b0, 1'b0);
    set_addr(16'h0001);
    rd_chk(A_D0, 8'h30);
    // Unlisted places and the identification bytes
    cfg_wr(16'h0015, 8'h55);
    set_addr(16'h0015);
    rd_chk(A_D0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      set_addr(DEV_ID_BASE + 16'(k));
      rd_chk(A_D0, DEV_ID_WORD[8*k +: 8]);
    end
    // Routing write is synchronized, then readable by address alone
    set_addr(16'h2001);
    d3(24'h00000a);
    host.wr(A_CMD, 8'h04);
    poll(n);
    set_addr(16'h2001);
    rd_chk(A_D0, 8'h0a);
    // Indirect access write then synchronized read, data regs cleared between
    set_addr(16'h4005);
    d3(24'h332211);
    host.wr(A_CMD, 8'h04);
    if (n > 0) rd_chk(A_CMD, 8'h01);
    poll(n);
    set_addr(16'h4005);
    d3(24'h000000);
    host.wr(A_CMD, 8'h02);
    poll(n);
    rd3(24'h332211);
    // Terminate a pending write; slot tick is not yet due after the poll
    set_addr(16'h5003);
    d3(24'h665544);
    host.wr(A_CMD, 8'h04);
    rd_chk(A_CMD, 8'h01);
    host.wr(A_CMD, 8'h08);
    rd_chk(A_CMD, 8'h00);
    // Direct mode maps both access memories by host address
    cfg_wr({11'h0, CFG_DIRECT_IX}, 8'h01);
    host.wr(10'h085, 8'h77);
    rd_chk(10'h085, 8'h77);
    rd_chk(10'h0c3, 8'h44);
    rd_chk(10'h010, 8'h00);
    set_addr(16'h4005);
    d3(24'h000000);
    host.wr(A_CMD, 8'h02);
    poll(n);
    rd3(24'h332277);
    // Soft reset holds the device and restores the config defaults
    host.wr(A_CMD, 8'h80);
    bit_chk(dev_reset, 1'b1);
    bit_chk(cfg_out.diag_mode, 1'b1);
    rd_chk(A_CMD, 8'h80);
    host.wr(A_CMD, 8'h00);
    bit_chk(dev_reset, 1'b0);
    set_addr(16'h0000);
    rd_chk(A_D0, CFG0_RST);
    // Direct mode back on, so the cleared access memory is what gets read
    cfg_wr({11'h0, CFG_DIRECT_IX}, 8'h01);
    rd_chk(10'h085, 8'h00);
    test_done();
  end

endmodule : ihp_host_port_test
